// ==== pfd_config.sv ====
// Operation
// - The internal RC postscaler code divides the RC clock by 1 to 64 in powers of two, top code by 256, reset code divide by one.
// - The feedback multiplier field in bits 8 to 0 sets a multiplier of its value plus two, from 2 to 513.
// - After reset the feedback multiplier field holds 000110000, a multiplier of 50.
// - Bits 15 to 9 of the feedback register and bit 5 of the divider register read zero and ignore writes.
// - While ratio_a enable is clear the processor to peripheral clock ratio is forced to 1:1.
// - Hardware clears ratio_a enable when recover on interrupt is set and an interrupt occurs.
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps

module pfd_config
    import pfd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // AXI4-Lite write address and data
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt event from the interrupt controller, same clock
    input wire logic interruptEvent,
    // Divided clock enables and the ratio_a active flag
    output logic fastInternalRcTick,
    output logic cpuTick,
    output logic dozeActive,
    // PLL division terms
    output logic [5:0] prescaleTerm,
    output logic [3:0] postscaleTerm,
    output logic [9:0] pllFeedbackMultiplier
);

    // ==========================================================
    // Bus handshake state
    // ==========================================================
    logic awReady_reg, awReady_next;
    logic wReady_reg, wReady_next;
    logic arReady_reg, arReady_next;
    logic bValid_reg, bValid_next;
    logic rValid_reg, rValid_next;
    logic [1:0] bResp_reg, bResp_next;
    logic [1:0] rResp_reg, rResp_next;
    logic [31:0] rData_reg, rData_next;
    logic [AXI_ADDR_W-1:0] wAddr_reg, wAddr_next;
    logic [31:0] wData_reg, wData_next;
    logic [3:0] wStrb_reg, wStrb_next;
    logic doWrite;
    logic [31:0] readWord;
    logic readHit;

    logic [15:0] divCfg_reg, divCfg_next;
    logic [15:0] fbDiv_reg, fbDiv_next;
    logic dozeActive_reg, dozeActive_next;
    logic [5:0] prescale_reg, prescale_next;
    logic [3:0] postscale_reg, postscale_next;
    logic [9:0] multiplier_reg, multiplier_next;
    logic [DIV_W-1:0] frcDivisor;
    logic [DIV_W-1:0] dozeRatio;
    logic [DIV_W-1:0] cpuDivisor;

    function automatic logic [15:0] mergeBytes(input logic [15:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [15:0] result;
        result = old;
        if (strb[0]) begin
            result[7:0] = data[7:0];
        end
        if (strb[1]) begin
            result[15:8] = data[15:8];
        end
        return result;
    endfunction

    // Both halves of a write must be held before it lands; the response follows.
    assign doWrite = !awReady_reg && !wReady_reg && !bValid_reg;

    always_comb begin
        readHit = 1'b1;
        unique case (s_axi_araddr)
            DIV_CFG_ADDR: readWord = {16'h0000, divCfg_reg};
            FB_DIV_ADDR: readWord = {16'h0000, fbDiv_reg};
            STATUS_ADDR: readWord = {23'h000000, dozeActive_reg, 3'h0, cpuDivisor[4:0]};
            default: begin
                readWord = 32'h00000000;
                readHit = 1'b0;
            end
        endcase
    end

    always_comb begin
        awReady_next = awReady_reg;
        wReady_next = wReady_reg;
        arReady_next = arReady_reg;
        bValid_next = bValid_reg;
        rValid_next = rValid_reg;
        bResp_next = bResp_reg;
        rResp_next = rResp_reg;
        rData_next = rData_reg;
        wAddr_next = wAddr_reg;
        wData_next = wData_reg;
        wStrb_next = wStrb_reg;
        if (awReady_reg && s_axi_awvalid) begin
            awReady_next = 1'b0;
            wAddr_next = s_axi_awaddr;
        end
        if (wReady_reg && s_axi_wvalid) begin
            wReady_next = 1'b0;
            wData_next = s_axi_wdata;
            wStrb_next = s_axi_wstrb;
        end
        if (doWrite) begin
            bValid_next = 1'b1;
            bResp_next = (wAddr_reg == DIV_CFG_ADDR || wAddr_reg == FB_DIV_ADDR ||
                          wAddr_reg == STATUS_ADDR) ? RESP_OKAY : RESP_SLVERR;
        end
        if (bValid_reg && s_axi_bready) begin
            bValid_next = 1'b0;
            awReady_next = 1'b1;
            wReady_next = 1'b1;
        end
        if (arReady_reg && s_axi_arvalid) begin
            arReady_next = 1'b0;
            rValid_next = 1'b1;
            rData_next = readWord;
            rResp_next = readHit ? RESP_OKAY : RESP_SLVERR;
        end
        if (rValid_reg && s_axi_rready) begin
            rValid_next = 1'b0;
            arReady_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            awReady_reg <= 1'b1;
            wReady_reg <= 1'b1;
            arReady_reg <= 1'b1;
            bValid_reg <= 1'b0;
            rValid_reg <= 1'b0;
            bResp_reg <= RESP_OKAY;
            rResp_reg <= RESP_OKAY;
            rData_reg <= 32'h00000000;
            wAddr_reg <= '0;
            wData_reg <= 32'h00000000;
            wStrb_reg <= 4'h0;
        end else begin
            awReady_reg <= awReady_next;
            wReady_reg <= wReady_next;
            arReady_reg <= arReady_next;
            bValid_reg <= bValid_next;
            rValid_reg <= rValid_next;
            bResp_reg <= bResp_next;
            rResp_reg <= rResp_next;
            rData_reg <= rData_next;
            wAddr_reg <= wAddr_next;
            wData_reg <= wData_next;
            wStrb_reg <= wStrb_next;
        end
    end

    assign s_axi_awready = awReady_reg;
    assign s_axi_wready = wReady_reg;
    assign s_axi_arready = arReady_reg;
    assign s_axi_bvalid = bValid_reg;
    assign s_axi_bresp = bResp_reg;
    assign s_axi_rvalid = rValid_reg;
    assign s_axi_rresp = rResp_reg;
    assign s_axi_rdata = rData_reg;

    // ==========================================================
    // Configuration registers
    // ==========================================================
    // The interrupt clear is applied after the write so that an interrupt in the
    // same cycle as a software write of the enable is never lost.
    always_comb begin
        divCfg_next = divCfg_reg;
        fbDiv_next = fbDiv_reg;
        if (doWrite && wAddr_reg == DIV_CFG_ADDR) begin
            divCfg_next = mergeBytes(divCfg_reg, wData_reg, wStrb_reg) & DIV_CFG_MASK;
        end
        if (doWrite && wAddr_reg == FB_DIV_ADDR) begin
            fbDiv_next = mergeBytes(fbDiv_reg, wData_reg, wStrb_reg) & FB_DIV_MASK;
        end
        if (divCfg_reg[ROI_BIT] && interruptEvent) begin
            divCfg_next[RATIO_A_ENABLE_BIT] = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            divCfg_reg <= DIV_CFG_RESET;
            fbDiv_reg <= FB_DIV_RESET;
        end else begin
            divCfg_reg <= divCfg_next;
            fbDiv_reg <= fbDiv_next;
        end
    end

    // ==========================================================
    // Division terms
    // ==========================================================
    always_comb begin
        unique case (divCfg_reg[FRC_LSB +: 3])
            FRC_TOP_CODE: frcDivisor = FRC_TOP_DIV;
            default: frcDivisor = DIV_BY_ONE << divCfg_reg[FRC_LSB +: 3];
        endcase
        unique case (divCfg_reg[RATIO_A_LSB +: 3])
            3'h0: dozeRatio = RATIO_A_R0;
            3'h1: dozeRatio = RATIO_A_R1;
            3'h2: dozeRatio = RATIO_A_R2;
            3'h3: dozeRatio = RATIO_A_R3;
            3'h4: dozeRatio = RATIO_A_R4;
            3'h5: dozeRatio = RATIO_A_R5;
            3'h6: dozeRatio = RATIO_A_R6;
            3'h7: dozeRatio = RATIO_A_R7;
        endcase
        unique case (divCfg_reg[POST_LSB +: 2])
            2'h0: postscale_next = POST_DIV_0;
            2'h1: postscale_next = POST_DIV_1;
            2'h2: postscale_next = POST_DIV_RSV;
            2'h3: postscale_next = POST_DIV_3;
        endcase
        // Output frequency is the input times this multiplier over both terms.
        prescale_next = 6'(divCfg_reg[PRE_LSB +: 5]) + 6'(PLL_TERM_OFFSET);
        multiplier_next = 10'(fbDiv_reg[FB_LSB +: 9]) + PLL_TERM_OFFSET;
        dozeActive_next = divCfg_reg[RATIO_A_ENABLE_BIT];
        cpuDivisor = dozeActive_reg ? dozeRatio : DIV_BY_ONE;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dozeActive_reg <= 1'b0;
            prescale_reg <= 6'(DIV_CFG_RESET[PRE_LSB +: 5]) + 6'(PLL_TERM_OFFSET);
            postscale_reg <= POST_DIV_1;
            multiplier_reg <= 10'(FB_DIV_RESET[FB_LSB +: 9]) + PLL_TERM_OFFSET;
        end else begin
            dozeActive_reg <= dozeActive_next;
            prescale_reg <= prescale_next;
            postscale_reg <= postscale_next;
            multiplier_reg <= multiplier_next;
        end
    end

    assign dozeActive = dozeActive_reg;
    assign prescaleTerm = prescale_reg;
    assign postscaleTerm = postscale_reg;
    assign pllFeedbackMultiplier = multiplier_reg;

    // ==========================================================
    // Clock enable dividers
    // ==========================================================
    // The RC clock is modelled as the system clock; only its enable is divided.
    pfd_tick_divider #(.W(DIV_W)) internal_rc_postscale (
        .sys_clk(sys_clk),
        .reset(reset),
        .divisor(frcDivisor),
        .tick(fastInternalRcTick)
    );

    pfd_tick_divider #(.W(DIV_W)) cpuDiv (
        .sys_clk(sys_clk),
        .reset(reset),
        .divisor(cpuDivisor),
        .tick(cpuTick)
    );

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence seq_write_lands(logic [7:0] addr);
        doWrite && wAddr_reg == addr;
    endsequence

    chk_post_top_code: assert property (divCfg_reg[POST_LSB +: 2] == 2'h3 |=>
        postscale_reg == 4'h8)
        else $error("Postscale code 11 did not give eight.");

    chk_pre_plus_two: assert property (1'b1 |=>
        prescale_reg == 6'($past(divCfg_reg[PRE_LSB +: 5])) + 6'h02)
        else $error("Prescale term is not field plus two.");

    chk_mult_plus_two: assert property (1'b1 |=>
        multiplier_reg == 10'($past(fbDiv_reg[8:0])) + 10'h002)
        else $error("Multiplier is not field plus two.");

    chk_mult_reset_value: assert property ($past(reset) |->
        fbDiv_reg[8:0] == 9'h030 && multiplier_reg == 10'h032)
        else $error("Multiplier reset value is not fifty.");

    chk_unimpl_read_zero: assert property (seq_write_lands(FB_DIV_ADDR) |=>
        fbDiv_reg[15:9] == 7'h00 && divCfg_reg[5] == 1'b0)
        else $error("Unimplemented bits took a write.");

    // The dividers restart at reset, so a window that opens on the last reset edge is skipped.
    chk_ratio_a_forced_one: assert property (!$past(reset) && !dozeActive_reg ##1 !dozeActive_reg |->
        cpuTick ##1 cpuTick)
        else $error("Processor clock not 1:1 with ratio_a clear.");

    chk_roi_clears_ratio_a: assert property (divCfg_reg[ROI_BIT] && interruptEvent |=>
        !divCfg_reg[RATIO_A_ENABLE_BIT] ##1 !dozeActive_reg)
        else $error("Interrupt did not clear ratio_a enable.");

    chk_ratio_a_ratio_used: assert property (dozeActive_reg |->
        cpuDivisor == dozeRatio)
        else $error("Processor divisor ignores ratio_a ratio.");

    chk_bresp_held: assert property (bValid_reg && !s_axi_bready |=>
        bValid_reg && $stable(bResp_reg))
        else $error("Write response dropped before taken.");

endmodule

// ==== pfd_pkg.sv ====
package pfd_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam int AXI_ADDR_W = 8;
    localparam logic [7:0] DIV_CFG_ADDR = 8'h00;
    localparam logic [7:0] FB_DIV_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Reset values and implemented-bit masks
    // ==========================================================
    localparam logic [15:0] DIV_CFG_RESET = 16'h3040;
    localparam logic [15:0] DIV_CFG_MASK = 16'hFFDF;
    localparam logic [15:0] FB_DIV_RESET = 16'h0030;
    localparam logic [15:0] FB_DIV_MASK = 16'h01FF;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int ROI_BIT = 15;
    localparam int RATIO_A_LSB = 12;
    localparam int RATIO_A_ENABLE_BIT = 11;
    localparam int FRC_LSB = 8;
    localparam int POST_LSB = 6;
    localparam int PRE_LSB = 0;
    localparam int FB_LSB = 0;
    localparam int STATUS_ACTIVE_BIT = 8;

    // ==========================================================
    // Divider values
    // ==========================================================
    localparam int DIV_W = 9;
    localparam logic [DIV_W-1:0] DIV_BY_ONE = 9'h001;
    localparam logic [DIV_W-1:0] FRC_TOP_DIV = 9'h100;
    localparam logic [2:0] FRC_TOP_CODE = 3'h7;
    localparam logic [9:0] PLL_TERM_OFFSET = 10'h002;
    localparam logic [3:0] POST_DIV_0 = 4'h2;
    localparam logic [3:0] POST_DIV_1 = 4'h4;
    localparam logic [3:0] POST_DIV_RSV = 4'h4;
    localparam logic [3:0] POST_DIV_3 = 4'h8;
    localparam logic [DIV_W-1:0] RATIO_A_R0 = 9'h001;
    localparam logic [DIV_W-1:0] RATIO_A_R1 = 9'h002;
    localparam logic [DIV_W-1:0] RATIO_A_R2 = 9'h004;
    localparam logic [DIV_W-1:0] RATIO_A_R3 = 9'h008;
    localparam logic [DIV_W-1:0] RATIO_A_R4 = 9'h010;
    localparam logic [DIV_W-1:0] RATIO_A_R5 = 9'h003;
    localparam logic [DIV_W-1:0] RATIO_A_R6 = 9'h006;
    localparam logic [DIV_W-1:0] RATIO_A_R7 = 9'h001;

endpackage

// ==== pfd_tick_divider.sv ====
`timescale 1ns/1ps

module pfd_tick_divider #(
    parameter int W = 9
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Division control, at least one
    input wire logic [W-1:0] divisor,
    // One-cycle pulse every divisor cycles
    output logic tick
);

    // ==========================================================
    // Counter
    // ==========================================================
    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    logic tick_reg;
    logic tick_next;

    // The compare is >= so that a divisor lowered mid-period ends the period at once.
    always_comb begin
        tick_next = (count_reg >= (divisor - W'(1)));
        count_next = tick_next ? '0 : count_reg + W'(1);
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

    // ==========================================================
    // Spacing check
    // ==========================================================
    logic [W-1:0] gap_reg;
    logic [W-1:0] gap_next;
    logic steady_reg;
    logic steady_next;
    logic [W-1:0] divPrev_reg;

    always_comb begin
        gap_next = tick_reg ? W'(1) : gap_reg + W'(1);
        steady_next = tick_reg ? 1'b1 : (steady_reg && (divisor == divPrev_reg));
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            gap_reg <= '0;
            steady_reg <= 1'b0;
            divPrev_reg <= '0;
        end else begin
            gap_reg <= gap_next;
            steady_reg <= steady_next;
            divPrev_reg <= divisor;
        end
    end

    chk_tick_gap_exact: assert property (@(posedge sys_clk) disable iff (reset)
        (tick_reg && steady_reg) |-> (gap_reg == divPrev_reg))
        else $error("Tick spacing differs from the steady divisor.");

endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps

module tb_top;
    import pfd_pkg::*;

    // ==========================================================
    // Stimulus and observed signals
    // ==========================================================
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic interruptEvent = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic fastInternalRcTick, cpuTick, dozeActive;
    logic [5:0] prescaleTerm;
    logic [3:0] postscaleTerm;
    logic [9:0] pllFeedbackMultiplier;
    logic [8:0] rcDiv [8] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h100};
    logic [8:0] dozeDiv [8] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h003, 9'h006, 9'h001};
    int err_count = 0;
    int n_tests = 0;

    always #10 sys_clk = ~sys_clk;

    pfd_config uut (
        .sys_clk(sys_clk),
        .reset(reset),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'h3),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .interruptEvent(interruptEvent),
        .fastInternalRcTick(fastInternalRcTick),
        .cpuTick(cpuTick),
        .dozeActive(dozeActive),
        .prescaleTerm(prescaleTerm),
        .postscaleTerm(postscaleTerm),
        .pllFeedbackMultiplier(pllFeedbackMultiplier)
    );

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got 0x%08h expected 0x%08h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("Comparisons: %0d, mismatches: %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Bus tasks are entered just after a rising edge and leave one edge after the
    // response handshake, so no strobe is lowered and raised in one time step.
    task automatic axi_write(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
        logic awDone, wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        r = 2'h1;
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (awDone && wDone && s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                break;
            end
            if (!awDone && s_axi_awready === 1'b1) begin
                awDone = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wDone && s_axi_wready === 1'b1) begin
                wDone = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic arDone;
        arDone = 1'b0;
        r = 2'h1;
        d = 32'hDEAD_BEEF;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (arDone && s_axi_rvalid === 1'b1) begin
                r = s_axi_rresp;
                d = s_axi_rdata;
                break;
            end
            if (!arDone && s_axi_arready === 1'b1) begin
                arDone = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
        end
        s_axi_rready <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        check(r, RESP_OKAY);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [1:0] r;
        logic [31:0] d;
        axi_read(a, d, r);
        check(r, RESP_OKAY);
        check(d, exp);
    endtask

    // Skips two ticks so a period begun under the old setting is never measured.
    task automatic period(input bit useCpu, output int p);
        p = 0;
        for (int k = 0; k < 3; k++) begin
            p = 0;
            do begin
                @(posedge sys_clk);
                p++;
            end while ((useCpu ? cpuTick : fastInternalRcTick) !== 1'b1 && p < 600);
        end
    endtask

    task automatic pulse_interrupt();
        interruptEvent <= 1'b1;
        @(posedge sys_clk);
        interruptEvent <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic test_reset();
        check(pllFeedbackMultiplier, 32'h32);
        check(prescaleTerm, 32'h2);
        check(postscaleTerm, 32'h4);
        rd(DIV_CFG_ADDR, 32'h3040);
        rd(FB_DIV_ADDR, 32'h30);
    endtask

    task automatic test_feedback();
        wr(FB_DIV_ADDR, 16'hFFFF);
        rd(FB_DIV_ADDR, 32'h1FF);
        check(pllFeedbackMultiplier, 32'h201);
        wr(FB_DIV_ADDR, 16'h0000);
        check(pllFeedbackMultiplier, 32'h2);
    endtask

    task automatic test_prescale();
        wr(DIV_CFG_ADDR, 16'h00C1);
        check(postscaleTerm, 32'h8);
        check(prescaleTerm, 32'h3);
        wr(DIV_CFG_ADDR, 16'h003F);
        rd(DIV_CFG_ADDR, 32'h1F);
        check(prescaleTerm, 32'h21);
    endtask

    task automatic test_rc_post();
        int p;
        for (int c = 0; c < 8; c++) begin
            wr(DIV_CFG_ADDR, 16'(c << 8));
            period(1'b0, p);
            check(p, rcDiv[c]);
        end
    endtask

    task automatic test_ratio_a();
        int p;
        wr(DIV_CFG_ADDR, 16'h4000);
        period(1'b1, p);
        check(p, 32'h1);
        check(dozeActive, 32'h0);
        for (int c = 0; c < 8; c++) begin
            wr(DIV_CFG_ADDR, 16'(c << 12) | 16'h0800);
            period(1'b1, p);
            check(p, dozeDiv[c]);
            check(dozeActive, 32'h1);
            rd(STATUS_ADDR, {23'h0, 1'b1, 3'h0, dozeDiv[c][4:0]});
        end
    endtask

    task automatic test_recover();
        int p;
        wr(DIV_CFG_ADDR, 16'h3800);
        pulse_interrupt();
        rd(DIV_CFG_ADDR, 32'h3800);
        wr(DIV_CFG_ADDR, 16'hB800);
        pulse_interrupt();
        rd(DIV_CFG_ADDR, 32'hB000);
        check(dozeActive, 32'h0);
        period(1'b1, p);
        check(p, 32'h1);
    endtask

    // An unmapped place must answer with an error and leave the map untouched.
    task automatic test_refused();
        logic [1:0] r;
        logic [31:0] d;
        wr(FB_DIV_ADDR, 16'h0030);
        axi_write(8'h0C, 16'hFFFF, r);
        check(r, RESP_SLVERR);
        axi_read(8'h0C, d, r);
        check(r, RESP_SLVERR);
        check(d, 32'h0);
        wr(STATUS_ADDR, 16'hFFFF);
        rd(FB_DIV_ADDR, 32'h30);
        rd(STATUS_ADDR, 32'h1);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        test_reset();
        test_feedback();
        test_prescale();
        test_rc_post();
        test_ratio_a();
        test_recover();
        test_refused();
        stop_test();
    end

    // The whole run needs well under two thousand cycles; this leaves a wide margin.
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        $display("Watchdog expired at %0t", $time);
        stop_test();
    end

endmodule
